// File: sdpsc_host_model.sv
// host model: shutdown line and a shortened slow clock
`timescale 1ns/100ps
module sdpsc_host_model #(parameter int HALF = 10, parameter int HOLD = 50) (
  // bench command and clock
  input  logic clk,
  input  logic shut_cmd,
  // pins driven into the device
  output logic shutdown_request_low = 1'b0,
  output logic slow_clk_in = 1'b0
);
  int half_cnt = 0;
  int low_cnt = 0;
  // free-running slow clock, period shortened to keep the run brief
  always @(posedge clk) begin
    if (half_cnt == HALF - 1) begin
      half_cnt <= 0;
      slow_clk_in <= ~slow_clk_in;
    end else half_cnt <= half_cnt + 1;
  end
  // shutdown released only after a minimum low time
  always @(posedge clk) begin
    if (shut_cmd) begin
      shutdown_request_low <= 1'b0;
      low_cnt <= 0;
    end else if (low_cnt >= HOLD) shutdown_request_low <= 1'b1;
    else low_cnt <= low_cnt + 1;
  end
endmodule

// File: sdpsc_pkg.sv
// package of constants and types for the shutdown and pin state control block
package sdpsc_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned CLK_HZ            = 100_000_000;
  localparam int unsigned SLOW_CLK_HZ       = 32768;
  // slow clock stable within this many slow cycles after release
  localparam int unsigned SLOW_SETTLE_CYC   = 64;
  // power-up done indication, longest time in ms
  localparam int unsigned READY_MAX_MS      = 100;
  localparam int unsigned READY_MAX_CYC     = READY_MAX_MS * (CLK_HZ / 1000);
  // least shutdown low time expected from the host, in ms
  localparam int unsigned SHUT_MIN_MS       = 5;
  localparam int unsigned SHUT_MIN_CYC      = SHUT_MIN_MS * (CLK_HZ / 1000);
  localparam int unsigned CNT_W             = 24;

  // ****************************************
  // pin indices and pull encoding
  // ****************************************
  localparam int unsigned NUM_PINS  = 9;
  localparam int unsigned PIN_RX    = 0;
  localparam int unsigned PIN_TX    = 1;
  localparam int unsigned PIN_RTS   = 2;
  localparam int unsigned PIN_CTS   = 3;
  localparam int unsigned PIN_ACLK  = 4;
  localparam int unsigned PIN_AFS   = 5;
  localparam int unsigned PIN_AIN   = 6;
  localparam int unsigned PIN_AOUT  = 7;
  localparam int unsigned PIN_DBG   = 8;

  // pull_up mask: rx tx rts cts dbg; the audio pins pull down
  localparam logic [8:0] PULL_UP_MASK   = 9'h10F;
  localparam logic [8:0] PULL_DOWN_MASK = 9'h0F0;
  // active mode drivers: tx, rts, debug transmit
  localparam logic [8:0] ACTIVE_OE_MASK = 9'h106;
  // active mode pulls: rx cts pull up, audio pins pull down, drivers none
  localparam logic [8:0] ACTIVE_PU_MASK = 9'h009;
  localparam logic [8:0] ACTIVE_PD_MASK = 9'h0F0;

  typedef enum {
    SDPSC_SHUTDOWN,
    SDPSC_SYNC,
    SDPSC_SETTLE,
    SDPSC_ACTIVE
  } sdpsc_mode_e;

  // drive and pull control for all managed pins
  typedef struct packed {
    logic [8:0] out;
    logic [8:0] oe;
    logic [8:0] pull_up;
    logic [8:0] pull_down;
  } sdpsc_pins_s;

endpackage

// File: sdpsc_slow_sync.sv
// slow clock synchroniser and rising edge enable
`timescale 1ns/100ps
module sdpsc_slow_sync
  import sdpsc_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // slow clock sample
  input  wire logic slow_clk_in,
  // one-cycle enable per slow clock rising edge
  output logic      slow_tick
);

  logic meta;
  logic sync;
  logic sync_d;

  // two flop synchroniser then edge detect on the second stage
  always_ff @(posedge clk) begin
    if (!rstn) begin
      meta      <= 1'b0;
      sync      <= 1'b0;
      sync_d    <= 1'b0;
      slow_tick <= 1'b0;
    end else begin
      meta      <= slow_clk_in;
      sync      <= meta;
      sync_d    <= sync;
      slow_tick <= sync & ~sync_d;
    end
  end

endmodule

// File: sdpsc_top.sv
// shutdown sequencing and power-mode pin state control
//
// Function
// - shutdown low keeps device reset, low power
// - pins hi-z with pulls during shutdown, power-up
// - both supplies: shutdown asserted off, released active
// - shutdown: host pins pull up, audio down
// - active: tx rts high outputs, inputs pulled
// - undriven shutdown pin reads as shutdown
// - ready-to-send low within 100 ms after release
//
// shutdown wins from every mode within one clock
// release waits for a synchronised slow clock edge, then the settle count
// a late slow clock only delays start-up, the core never runs half-reset
// the host's minimum low time is not measured
// a forbidden supply combination is flagged, not acted on
// the ready watchdog only raises a flag
`timescale 1ns/100ps
module sdpsc_top
  import sdpsc_pkg::*;
(
  // clock and reset
  input  wire logic  clk,
  input  wire logic  rstn,
  // shutdown pin, sampled with its pull-down resolved
  input  wire logic  shutdown_request_low,
  input  wire logic  shutdown_pin_driven,
  // supply presence
  input  wire logic  core_supply_ok,
  input  wire logic  io_supply_ok,
  // slow clock pin
  input  wire logic  slow_clk_in,
  // core side
  input  wire logic  core_ready,
  input  wire logic  core_tx_data,
  input  wire logic  core_rts_busy,
  input  wire logic  core_dbg_data,
  input  wire logic  core_audio_out_en,
  input  wire logic  core_audio_out,
  // state to core
  output logic       core_reset_low,
  output logic       low_power,
  output logic       slow_clk_valid,
  output logic       illegal_supply,
  output logic       ready_late,
  output sdpsc_pins_s pins
);

  // power mode and its next value
  sdpsc_mode_e mode;
  sdpsc_mode_e next_mode;
  // shutdown as seen through the pin's pull-down
  logic        shut_eff;
  // one pulse per synchronised slow clock rising edge
  logic        slow_tick;
  // slow clock cycles counted while settling
  logic [6:0]  slow_cnt;
  // clock cycles since release, for the ready watchdog
  logic [CNT_W-1:0] ready_cnt;
  logic        release_seen;

  // internal pull-down: an undriven pin counts as shutdown
  assign shut_eff = ~shutdown_pin_driven | ~shutdown_request_low;

  // ****************************************
  // mode and pin decode
  // ****************************************
  // the one mode where the core runs and pins take their active setup
  function automatic logic mode_active(input sdpsc_mode_e m);
    return (m == SDPSC_ACTIVE);
  endfunction

  // the mode that draws the least power and holds the core in reset
  function automatic logic mode_shutdown(input sdpsc_mode_e m);
    return (m == SDPSC_SHUTDOWN);
  endfunction

  // tri-stated pins with their shutdown pulls on, for reset and all modes but active
  function automatic sdpsc_pins_s idle_pins();
    sdpsc_pins_s p;
    p.out       = 9'h000;
    p.oe        = 9'h000;
    p.pull_up   = PULL_UP_MASK;
    p.pull_down = PULL_DOWN_MASK;
    return p;
  endfunction

  // ****************************************
  // slow clock edge enable
  // ****************************************
  sdpsc_slow_sync u_slow_sync (
    .clk         (clk),
    .rstn        (rstn),
    .slow_clk_in (slow_clk_in),
    .slow_tick   (slow_tick)
  );

  // ****************************************
  // power mode sequencing
  // ****************************************
  // next mode from shutdown pin, slow clock ticks and settle count
  always_comb begin
    next_mode = mode;
    unique case (mode)
      SDPSC_SHUTDOWN: begin
        if (!shut_eff) begin
          next_mode = SDPSC_SYNC;
        end
      end
      SDPSC_SYNC: begin
        if (slow_tick) begin
          next_mode = SDPSC_SETTLE;
        end
      end
      SDPSC_SETTLE: begin
        if (slow_tick && slow_cnt == 7'(SLOW_SETTLE_CYC - 1)) begin
          next_mode = SDPSC_ACTIVE;
        end
      end
      SDPSC_ACTIVE: begin
        next_mode = SDPSC_ACTIVE;
      end
    endcase
    if (shut_eff) begin
      next_mode = SDPSC_SHUTDOWN;
    end
  end

  // mode register
  always_ff @(posedge clk) begin
    if (!rstn) begin
      mode <= SDPSC_SHUTDOWN;
    end else begin
      mode <= next_mode;
    end
  end

  // slow cycles counted since the synchronised release
  // cleared outside settle, so each release counts from zero
  always_ff @(posedge clk) begin
    if (!rstn || mode != SDPSC_SETTLE) begin
      slow_cnt <= 7'h00;
    end else if (slow_tick) begin
      slow_cnt <= slow_cnt + 7'h01;
    end
  end

  // ****************************************
  // core reset and status
  // ****************************************
  // core held in reset until the slow clock has settled
  always_ff @(posedge clk) begin
    if (!rstn) begin
      core_reset_low <= 1'b0;
      low_power      <= 1'b1;
      slow_clk_valid <= 1'b0;
    end else begin
      core_reset_low <= mode_active(next_mode);
      low_power      <= mode_shutdown(next_mode);
      slow_clk_valid <= mode_active(next_mode);
    end
  end

  // released shutdown without both supplies is a forbidden combination
  // a level, it drops as soon as the combination is legal again
  always_ff @(posedge clk) begin
    if (!rstn) begin
      illegal_supply <= 1'b0;
    end else begin
      illegal_supply <= ~shut_eff & ~(core_supply_ok & io_supply_ok);
    end
  end

  // watchdog on the power-up done indication
  // the count freezes once the core is ready in active mode
  always_ff @(posedge clk) begin
    if (!rstn || shut_eff) begin
      ready_cnt    <= '0;
      release_seen <= 1'b0;
      ready_late   <= 1'b0;
    end else begin
      release_seen <= 1'b1;
      if (mode == SDPSC_ACTIVE && core_ready) begin
        ready_cnt <= ready_cnt;
      end else if (ready_cnt != CNT_W'(READY_MAX_CYC - 1)) begin
        ready_cnt <= ready_cnt + CNT_W'(1);
      end else begin
        ready_late <= release_seen;
      end
    end
  end

  // ****************************************
  // pin states
  // ****************************************
  // pins tri-stated with pulls until active, then active mode drive
  always_ff @(posedge clk) begin
    if (!rstn) begin
      pins <= idle_pins();
    end else if (!mode_active(next_mode)) begin
      pins <= idle_pins();
    end else begin
      pins.oe        <= ACTIVE_OE_MASK;
      pins.pull_up   <= ACTIVE_PU_MASK;
      pins.pull_down <= ACTIVE_PD_MASK;
      pins.out       <= 9'h000;
      pins.out[PIN_TX]  <= core_ready ? core_tx_data : 1'b1;
      // ready-to-send idles high, then follows core_rts_busy once the core reports power-up done
      pins.out[PIN_RTS] <= core_ready ? core_rts_busy : 1'b1;
      // debug transmit is a plain output with no pull
      pins.out[PIN_DBG] <= core_dbg_data;
      // audio data-out stays hi-z with its pull-down until the core reports power-up done and enables it
      if (core_ready && core_audio_out_en) begin
        pins.oe[PIN_AOUT]  <= 1'b1;
        pins.out[PIN_AOUT] <= core_audio_out;
      end
    end
  end

endmodule

// File: sdpsc_top_sva.sv
// port checker for the shutdown and pin state control block
`timescale 1ns/100ps
module sdpsc_top_sva
  import sdpsc_pkg::*;
(
  // clock and reset
  input logic        clk,
  input logic        rstn,
  // shutdown pin and supplies
  input logic        shutdown_request_low,
  input logic        shutdown_pin_driven,
  input logic        core_supply_ok,
  input logic        io_supply_ok,
  // slow clock and core side
  input logic        slow_clk_in,
  input logic        core_ready,
  input logic        core_tx_data,
  input logic        core_rts_busy,
  input logic        core_dbg_data,
  input logic        core_audio_out_en,
  input logic        core_audio_out,
  // block outputs
  input logic        core_reset_low,
  input logic        low_power,
  input logic        slow_clk_valid,
  input logic        illegal_supply,
  input logic        ready_late,
  input sdpsc_pins_s pins
);
  // shutdown as the pin resolves it, pull-down included
  wire shut = !shutdown_pin_driven | !shutdown_request_low;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  shut_holds_reset_a: assert property (shut |=> !core_reset_low && low_power)
    else $error("core not held in reset during shutdown");
  float_pin_shut_a: assert property (!shutdown_pin_driven |=> low_power && !core_reset_low)
    else $error("floating shutdown pin left device running");
  hiz_pulls_a: assert property (!core_reset_low |-> pins.oe == 9'h000 && pins.pull_up == 9'h10F
    && pins.pull_down == 9'h0F0) else $error("pins not released with pulls");
  active_pins_a: assert property (core_reset_low |-> pins.oe[6:0] == 7'h06 && pins.oe[8]
    && pins.pull_up == 9'h009 && pins.pull_down == 9'h0F0) else $error("active pin setup wrong");
  idle_high_a: assert property (core_reset_low && !core_ready && !$past(core_ready) |-> pins.out[2:1] == 2'h3)
    else $error("transmit or ready line not idling high");
  rts_ready_a: assert property (core_reset_low && $past(core_reset_low) && core_ready && $past(core_ready)
    && $stable(core_rts_busy) |-> pins.out[2] == core_rts_busy) else $error("ready line not following core");
  active_state_a: assert property (core_reset_low |-> !low_power && slow_clk_valid)
    else $error("active mode flags wrong");
  sync_wait_a: assert property ($rose(shutdown_request_low) && shutdown_pin_driven |-> !core_reset_low [*8])
    else $error("reset released before slow clock wait");
  bad_supply_a: assert property (!shut && !(core_supply_ok && io_supply_ok) [*2] |-> illegal_supply)
    else $error("missing supply not flagged");
  late_clear_a: assert property (shut |=> !ready_late)
    else $error("late flag not cleared in shutdown");
  supply_ok_a: assert property (core_supply_ok && io_supply_ok |=> !illegal_supply)
    else $error("supply flag raised with both supplies");
  cover property ($rose(core_reset_low));
  cover property (illegal_supply);
  cover property (core_reset_low && core_ready && !pins.out[2]);
  cover property (!shutdown_pin_driven ##1 low_power);
endmodule
bind sdpsc_top sdpsc_top_sva chk (.*);

// File: tb_sdpsc_top.sv
// testbench for the shutdown and pin state control block
`timescale 1ns/100ps
module tb_sdpsc_top;
  import sdpsc_pkg::*;
  logic clk = 0, rstn = 0, shut_cmd = 1, driven = 1, core_ok = 1, io_ok = 1, core_ready = 0, core_rts_busy = 0;
  logic shutdown_request_low, slow_clk_in, core_reset_low, low_power, slow_clk_valid, illegal_supply, ready_late;
  sdpsc_pins_s pins;
  int fail_count = 0;
  int comparisons = 0;
  int n;
  initial forever #5 clk = ~clk;  // fast clock stable from time zero
  sdpsc_host_model #(.HALF(10)) host (.clk(clk), .shut_cmd(shut_cmd), .shutdown_request_low(shutdown_request_low),
    .slow_clk_in(slow_clk_in));
  sdpsc_top uut (.clk(clk), .rstn(rstn), .shutdown_request_low(shutdown_request_low), .shutdown_pin_driven(driven),
    .core_supply_ok(core_ok), .io_supply_ok(io_ok), .slow_clk_in(slow_clk_in), .core_ready(core_ready),
    .core_tx_data(1'b0), .core_rts_busy(core_rts_busy), .core_dbg_data(1'b0), .core_audio_out_en(1'b0),
    .core_audio_out(1'b0), .core_reset_low(core_reset_low), .low_power(low_power), .slow_clk_valid(slow_clk_valid),
    .illegal_supply(illegal_supply), .ready_late(ready_late), .pins(pins));
  task check(string name, logic [35:0] seen, logic [35:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task step(int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task shut_state;
    check("shutdown flags", {low_power, core_reset_low, pins.oe}, {2'h2, 9'h000});
    check("shutdown pulls", {pins.pull_up, pins.pull_down}, {9'h10F, 9'h0F0});
  endtask
  // release shutdown and count cycles from pin release to active
  task power_up;
    @(posedge clk);
    shut_cmd <= 0;
    n = 0;
    while (core_reset_low !== 1'b1 && n < 4000) begin
      step(1);
      if (shutdown_request_low) n++;
    end
    check("power up span", n >= 1280 && n <= 1320, 1);
  endtask
  task t_active;
    power_up;
    check("active flags", {low_power, slow_clk_valid}, 2'h1);
    check("active status", {illegal_supply, ready_late}, 2'h0);
    check("active drive", {pins.oe, pins.out}, {9'h106, 9'h006});
    check("active pulls", {pins.pull_up, pins.pull_down}, {9'h009, 9'h0F0});
    core_ready <= 1;
    core_rts_busy <= 0;
    step(3);
    check("ready line low", pins.out[2], 0);
    $display("test active done");
  endtask
  task t_shutdown;
    shut_cmd <= 1;
    core_ready <= 0;
    step(2);
    shut_state;
    $display("test shutdown done");
  endtask
  task t_float;
    power_up;
    driven <= 0;
    step(2);
    shut_state;
    shut_cmd <= 1;
    driven <= 1;
    $display("test floating pin done");
  endtask
  task t_bad_supply;
    @(posedge clk);
    io_ok <= 0;
    shut_cmd <= 0;
    step(60);
    check("supply flag", illegal_supply, 1);
    shut_cmd <= 1;
    io_ok <= 1;
    step(3);
    check("supply flag clear", illegal_supply, 0);
    $display("test bad supply done");
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1;
    step(1);
    shut_state;
    t_active;
    t_shutdown;
    t_float;
    t_bad_supply;
    end_sim;
  end
  initial begin
    #200000;
    fail_count++;
    end_sim;
  end
endmodule
